/* design/usf_top.v */
// USB SOF frame number capture and endpoint interrupt enable, APB slave.
// Assumes APB master on i_clk; receiver pulses and endpoint sources synchronous.
//
// Function
// - Enable bits 0-5 gate endpoint interrupts
// - Reserved bits read zero; software writes zero
// - Good flag set on clean SOF
// - Bad flag set on corrupted SOF
// - Both flags refreshed every SOF
// - SOF interrupt raised at PID receipt
// - Frame number split high 3, low 8
// - Frame number loaded even when corrupted
// - Frame registers read-only, writes ignored
// - Endpoint interrupt needs flag and enable
// - Flag follows any source, auto-clears
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "usf_consts.vh"

module usf_top (
    // Clock and reset
    input  wire                       i_clk,
    input  wire                       i_rst_b,
    // APB slave
    input  wire                       i_psel,
    input  wire                       i_penable,
    input  wire                       i_pwrite,
    input  wire [`USF_ADDR_W-1:0]     i_paddr,
    input  wire [31:0]                i_pwdata,
    output reg  [31:0]                o_prdata,
    output reg                        o_pready,
    output reg                        o_pslverr,
    // SOF receiver
    input  wire                       i_sof_pid,
    input  wire                       i_sof_done,
    input  wire [10:0]                i_sof_frame,
    input  wire                       i_sof_crc_bad,
    // Endpoint status sources, five per endpoint
    input  wire [`USF_EP_N*5-1:0]     i_ep_src,
    // Interrupt and flag outputs
    output reg  [`USF_EP_N-1:0]       o_ep_flag,
    output reg                        o_sof_flag,
    output reg                        o_irq
);

    // ------------------------------------------------------------------------
    // Address map in bytes
    // ------------------------------------------------------------------------
    localparam [`USF_ADDR_W-1:0] A_LOW  = {2'b00, `USF_IDX_SOF_FRAME_INDEX_LOW, 2'b00};
    localparam [`USF_ADDR_W-1:0] A_HIGH = {2'b00, `USF_IDX_SOF_FRAME_INDEX_HIGH, 2'b00};
    localparam [`USF_ADDR_W-1:0] A_IEN  = {2'b00, `USF_IDX_EP_IEN, 2'b00};
    localparam [`USF_ADDR_W-1:0] A_STAT = {2'b00, `USF_IDX_IRQ_STAT, 2'b00};
    localparam [`USF_ADDR_W-1:0] A_EN   = {2'b00, `USF_IDX_IRQ_EN, 2'b00};
    localparam [`USF_ADDR_W-1:0] A_CLR  = {2'b00, `USF_IDX_IRQ_CLR, 2'b00};

    // ------------------------------------------------------------------------
    // Registers and internal signals
    // ------------------------------------------------------------------------
    reg  [`USF_EP_N-1:0]  ep_allow_reg;    // Endpoint enables, software owned
    reg  [`USF_ST_W-1:0]  stat_reg;        // Sticky event status
    reg  [`USF_ST_W-1:0]  stat_next;       // Next status
    reg  [`USF_ST_W-1:0]  en_reg;          // Status interrupt enables
    reg  [31:0]           rd_next;         // Read mux result
    reg                   hit;             // Address decodes to a register
    wire [10:0]           frame;           // Captured frame number
    wire                  fr_good;         // Last SOF clean
    wire                  fr_bad;          // Last SOF corrupted
    wire                  sof_evt;         // PID seen pulse
    wire [`USF_EP_N-1:0]  ep_flag;         // Endpoint flags
    wire                  ep_irq;          // Enabled endpoint interrupt
    wire                  acc;             // APB access phase
    wire                  wr;              // Write takes effect
    wire [`USF_ST_W-1:0]  clr;             // Write-one-to-clear mask
    wire [`USF_ST_W-1:0]  evt;             // Events this cycle
    reg                   ep_irq_dly;      // Previous endpoint interrupt level

    // ------------------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------------------
    usf_sof_cap u_sof (
        .i_clk         (i_clk),
        .i_rst_b       (i_rst_b),
        .i_sof_pid     (i_sof_pid),
        .i_sof_done    (i_sof_done),
        .i_sof_frame   (i_sof_frame),
        .i_sof_crc_bad (i_sof_crc_bad),
        .o_frame       (frame),
        .o_good        (fr_good),
        .o_bad         (fr_bad),
        .o_sof_evt     (sof_evt)
    );

    usf_ep_irq #(
        .EP_N  (`USF_EP_N),
        .SRC_N (5)
    ) u_ep (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_src   (i_ep_src),
        .i_allow (ep_allow_reg),
        .o_flag  (ep_flag),
        .o_irq   (ep_irq)
    );

    // ------------------------------------------------------------------------
    // APB decode; one wait state, so every access ends in its second access cycle
    // ------------------------------------------------------------------------
    assign acc = i_psel & i_penable;
    assign wr  = acc & i_pwrite & ~o_pready;
    assign clr = (wr && i_paddr == A_CLR) ? i_pwdata[`USF_ST_W-1:0]
                                           : {`USF_ST_W{1'b0}};
    // Endpoint event is the rising edge of the enabled level
    assign evt = {ep_irq & ~ep_irq_dly, sof_evt};

    // Read mux; reserved bits come back as zero
    always @* begin
        rd_next = 32'h0000_0000;
        hit     = 1'b1;
        case (i_paddr)
            A_LOW: begin
                rd_next[7:0] = frame[7:0];
            end
            A_HIGH: begin
                rd_next[2:0] = frame[10:8];
                rd_next[`USF_HI_GOOD_BIT] = fr_good;
                rd_next[`USF_HI_BAD_BIT]  = fr_bad;
            end
            A_IEN: begin
                rd_next[`USF_EP_N-1:0] = ep_allow_reg;
            end
            A_STAT: begin
                rd_next[`USF_ST_W-1:0] = stat_reg;
            end
            A_EN: begin
                rd_next[`USF_ST_W-1:0] = en_reg;
            end
            A_CLR: begin
                rd_next = 32'h0000_0000;                             // Write-only
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // APB answer: pready one cycle into access, error on unmapped address
    // ------------------------------------------------------------------------
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
        end else if (acc && !o_pready) begin
            o_pready  <= 1'b1;
            o_pslverr <= ~hit;
            o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_next;
        end else begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------------
    // Software registers; frame registers take no write at all
    // ------------------------------------------------------------------------
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            ep_allow_reg <= {`USF_EP_N{1'b0}};
            en_reg       <= {`USF_ST_W{1'b0}};
        end else if (wr) begin
            // Writes to A_LOW and A_HIGH fall through untouched
            if (i_paddr == A_IEN) begin
                ep_allow_reg <= i_pwdata[`USF_EP_N-1:0];
            end
            if (i_paddr == A_EN) begin
                en_reg <= i_pwdata[`USF_ST_W-1:0];
            end
        end
    end

    // Sticky status: a set in the clearing cycle wins
    always @* begin
        stat_next = (stat_reg & ~clr) | evt;
    end

    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            stat_reg   <= {`USF_ST_W{1'b0}};
            ep_irq_dly <= 1'b0;
        end else begin
            stat_reg   <= stat_next;
            ep_irq_dly <= ep_irq;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs, all registered
    // ------------------------------------------------------------------------
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_ep_flag  <= {`USF_EP_N{1'b0}};
            o_sof_flag <= 1'b0;
            o_irq      <= 1'b0;
        end else begin
            o_ep_flag  <= ep_flag;
            o_sof_flag <= stat_next[`USF_ST_SOF_BIT];
            // Level: any enabled sticky bit; an endpoint counts only through its edge-set sticky bit
            o_irq      <= |(stat_next & en_reg);
        end
    end

endmodule // usf_top

`default_nettype wire

/* inc/usf_consts.vh */
// Constants for the SOF frame-number capture and endpoint interrupt enable block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef USF_CONSTS_VH
`define USF_CONSTS_VH

// ----------------------------------------------------------------------------
// Register byte addresses (printed offsets are not all multiples of four,
// so each printed offset is an index and the byte address is four times it)
// ----------------------------------------------------------------------------
`define USF_IDX_SOF_FRAME_INDEX_LOW     8'hba
`define USF_IDX_SOF_FRAME_INDEX_HIGH    8'hbb
`define USF_IDX_EP_IEN       8'hbc
`define USF_IDX_IRQ_STAT     8'hbd
`define USF_IDX_IRQ_EN       8'hbe
`define USF_IDX_IRQ_CLR      8'hbf
`define USF_ADDR_W           12

// ----------------------------------------------------------------------------
// Field positions in the high register
// ----------------------------------------------------------------------------
`define USF_HI_GOOD_BIT      5
`define USF_HI_BAD_BIT       4

// ----------------------------------------------------------------------------
// Interrupt status bit positions
// ----------------------------------------------------------------------------
`define USF_ST_SOF_BIT       0
`define USF_ST_EP_BIT        1
`define USF_ST_W             2

// ----------------------------------------------------------------------------
// Reset values and endpoint count
// ----------------------------------------------------------------------------
`define USF_RST_BYTE         8'h00
`define USF_EP_N             6

`endif

/* design/usf_ep_irq.v */
// Per-endpoint interrupt flags and enable gating.
// Assumes status sources arrive as synchronous levels, one group per endpoint.
`timescale 1ns/100ps
`default_nettype none

module usf_ep_irq #(
    parameter EP_N  = 6,               // Number of endpoints
    parameter SRC_N = 5                // Status sources per endpoint
) (
    // Clock and reset
    input  wire                   i_clk,
    input  wire                   i_rst_b,
    // Sources and enables
    input  wire [EP_N*SRC_N-1:0]  i_src,
    input  wire [EP_N-1:0]        i_allow,
    // Results
    output reg  [EP_N-1:0]        o_flag,
    output reg                    o_irq
);

    reg  [EP_N-1:0] gate_next;         // Enabled flags before registering
    genvar          g;

    // ------------------------------------------------------------------------
    // Flag per endpoint: follows OR of its sources
    // ------------------------------------------------------------------------
    generate
        for (g = 0; g < EP_N; g = g + 1) begin : g_ep
            // Set on any source, drops only when all are gone
            always @(posedge i_clk) begin
                if (!i_rst_b) begin
                    o_flag[g] <= 1'b0;
                end else begin
                    o_flag[g] <= |i_src[g*SRC_N +: SRC_N];
                end
            end
        end
    endgenerate

    // Enabled flags, computed from the same sources so irq aligns with flag
    always @* begin : p_gate
        integer k;
        gate_next = {EP_N{1'b0}};
        for (k = 0; k < EP_N; k = k + 1) begin
            gate_next[k] = (|i_src[k*SRC_N +: SRC_N]) & i_allow[k];
        end
    end

    // ------------------------------------------------------------------------
    // Combined endpoint interrupt
    // ------------------------------------------------------------------------
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |gate_next;
        end
    end

endmodule // usf_ep_irq

`default_nettype wire

/* design/usf_sof_cap.v */
// Start of Frame capture: frame number and CRC result flags.
// Assumes the receiver gives a PID pulse, then a done pulse with the number.
`timescale 1ns/100ps
`default_nettype none

module usf_sof_cap (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_rst_b,
    // Receiver side
    input  wire        i_sof_pid,      // PID decoded, one-cycle pulse
    input  wire        i_sof_done,     // Packet end, one-cycle pulse
    input  wire [10:0] i_sof_frame,    // Frame number with done
    input  wire        i_sof_crc_bad,  // CRC result with done
    // Captured values
    output reg  [10:0] o_frame,
    output reg         o_good,
    output reg         o_bad,
    output reg         o_sof_evt       // One-cycle pulse on PID
);

    // ------------------------------------------------------------------------
    // Early event on the PID, before the number is known
    // ------------------------------------------------------------------------
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_sof_evt <= 1'b0;
        end else begin
            o_sof_evt <= i_sof_pid;
        end
    end

    // ------------------------------------------------------------------------
    // Atomic update at packet end; number loaded even when corrupted
    // ------------------------------------------------------------------------
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_frame <= 11'h000;
            o_good  <= 1'b0;
            o_bad   <= 1'b0;
        end else if (i_sof_done) begin
            o_frame <= i_sof_frame;
            o_good  <= ~i_sof_crc_bad;
            o_bad   <= i_sof_crc_bad;
        end
    end

endmodule // usf_sof_cap

`default_nettype wire

/* sim/usf_top_properties.sv */
// Checker: port-level timing and read-value properties of usf_top.
// Assumes bind to usf_top; one clock, synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
`include "usf_consts.vh"

module usf_top_properties (
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst_b,
    // APB
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    // SOF and endpoints
    input wire logic        i_sof_pid,
    input wire logic [29:0] i_ep_src,
    input wire logic [5:0]  o_ep_flag,
    input wire logic        o_sof_flag
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    logic [5:0] src_or;  // Any source active, per endpoint
    logic       rd_ok;   // Completed read this cycle
    always_comb begin
        for (int k = 0; k < 6; k++) src_or[k] = |i_ep_src[5*k +: 5];
    end
    assign rd_ok = o_pready && !i_pwrite;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence s_pid;
        i_sof_pid;
    endsequence
    sequence s_flag_up;
        ##2 o_sof_flag;
    endsequence
    property p_sof_irq;
        s_pid |-> s_flag_up;
    endproperty
    a_sof_irq: assert property (p_sof_irq) else $error("sof flag late");
    // Source to internal flag is one register, then the output register
    property p_ep_flag;
        1'b1 |=> o_ep_flag == $past(src_or, 2);
    endproperty
    a_ep_flag: assert property (p_ep_flag) else $error("ep flag wrong");
    property p_hi_rsvd;
        rd_ok && i_paddr == 12'h2ec |-> o_prdata[31:6] == 0 && !o_prdata[3]
            && !(o_prdata[5] && o_prdata[4]);
    endproperty
    a_hi_rsvd: assert property (p_hi_rsvd) else $error("high reg bad");
    property p_en_rsvd;
        rd_ok && i_paddr == 12'h2f0 |-> o_prdata[31:6] == 0;
    endproperty
    a_en_rsvd: assert property (p_en_rsvd) else $error("enable reg bad");
    property p_ready;
        i_psel && i_penable && !o_pready |=> o_pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready late");
    property p_pulse;
        o_pready |=> !o_pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pready long");
    property p_err;
        o_pslverr |-> o_pready;
    endproperty
    a_err: assert property (p_err) else $error("stray pslverr");
    property p_unmap;
        o_pready && i_paddr < 12'h2e8 |-> o_pslverr;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped ok");
    property p_idle;
        !o_pready |-> o_prdata == 32'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("prdata not idle");
endmodule // usf_top_properties
`default_nettype wire

/* sim/usf_host_model.sv */
// Host side model: issues SOF packets as receiver pulses.
// Assumes the bench calls send_sof; one clock, no reset needed.
`timescale 1ns/100ps
`default_nettype none

module usf_host_model (
    input  wire logic   i_clk,
    output logic        o_pid,
    output logic        o_done,
    output logic [10:0] o_frame,
    output logic        o_crc_bad
);
    // Idle lines; frame shows no stale number between packets
    initial begin
        o_pid = 1'b0;
        o_done = 1'b0;
        o_frame = 11'h555;
        o_crc_bad = 1'b1;
    end

    // PID first, then gap cycles of token, then end with result
    task automatic send_sof(input logic [10:0] fn, input logic bad, input int gap);
        @(posedge i_clk);
        o_pid <= 1'b1;
        @(posedge i_clk);
        o_pid <= 1'b0;
        repeat (gap) @(posedge i_clk);
        o_frame <= fn;
        o_crc_bad <= bad;
        o_done <= 1'b1;
        @(posedge i_clk);
        o_done <= 1'b0;
        o_frame <= ~fn;     // Inverse, so a late sample is caught
        o_crc_bad <= ~bad;
    endtask
endmodule // usf_host_model
`default_nettype wire

/* sim/usf_top_tb.sv */
// Testbench: APB register tests, SOF capture, endpoint interrupts.
// Assumes usf_top, usf_host_model and the property checker compiled.
`timescale 1ns/100ps
`default_nettype none

module usf_top_tb;
    logic        i_clk = 1'b0;      // 50 MHz
    logic        i_rst_b = 1'b0;
    logic        i_psel = 1'b0;
    logic        i_penable = 1'b0;
    logic        i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h0;
    logic [31:0] i_pwdata = 32'h0;
    logic [29:0] i_ep_src = 30'h0;
    logic [31:0] o_prdata, rd;
    logic        o_pready, o_pslverr, err, o_sof_flag, o_irq;
    logic        i_sof_pid, i_sof_done, i_sof_crc_bad;
    logic [10:0] i_sof_frame;
    logic [5:0]  o_ep_flag;
    int          n_errors = 0;
    int          tests_run = 0;
    int          k;

    always #10 i_clk = ~i_clk;

    usf_top dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_sof_pid(i_sof_pid), .i_sof_done(i_sof_done),
        .i_sof_frame(i_sof_frame), .i_sof_crc_bad(i_sof_crc_bad),
        .i_ep_src(i_ep_src), .o_ep_flag(o_ep_flag), .o_sof_flag(o_sof_flag),
        .o_irq(o_irq));
    usf_host_model host (.i_clk(i_clk), .o_pid(i_sof_pid), .o_done(i_sof_done),
        .o_frame(i_sof_frame), .o_crc_bad(i_sof_crc_bad));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        for (i = 0; i < 20 && o_pready !== 1'b1; i++) @(posedge i_clk);
        if (i == 20) begin
            n_errors++;
            final_report();
        end
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic tdone(input string s);
        $display("test %s done", s);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        rchk(12'h2f0, 32'h0);
        rchk(12'h2ec, 32'h0);
        rchk(12'h2f4, 32'h0);
        tdone("reset");
        apb(1'b1, 12'h2f0, 32'h2a);
        rchk(12'h2f0, 32'h2a);
        apb(1'b1, 12'h2f0, 32'h15);
        rchk(12'h2f0, 32'h15);
        tdone("enable");
        host.send_sof(11'h5a3, 1'b0, 3);
        rchk(12'h2e8, 32'ha3);
        rchk(12'h2ec, 32'h25);
        host.send_sof(11'h7ff, 1'b1, 0);
        rchk(12'h2e8, 32'hff);
        rchk(12'h2ec, 32'h17);
        host.send_sof(11'h001, 1'b0, 8);
        rchk(12'h2ec, 32'h20);
        rchk(12'h2e8, 32'h01);
        tdone("frame");
        apb(1'b1, 12'h2e8, 32'hff);
        apb(1'b1, 12'h2ec, 32'h37);
        chk(err, 1'b0);
        rchk(12'h2e8, 32'h01);
        rchk(12'h2ec, 32'h20);
        tdone("read_only");
        apb(1'b1, 12'h2fc, 32'h3);
        apb(1'b1, 12'h2f8, 32'h1);
        chk(o_irq, 1'b0);
        host.send_sof(11'h123, 1'b0, 2);
        chk(o_sof_flag, 1'b1);
        rchk(12'h2f4, 32'h1);
        chk(o_irq, 1'b1);
        apb(1'b1, 12'h2fc, 32'h1);
        rchk(12'h2f4, 32'h0);
        chk(o_irq, 1'b0);
        apb(1'b1, 12'h2f8, 32'h0);
        host.send_sof(11'h124, 1'b0, 1);
        rchk(12'h2f4, 32'h1);
        chk(o_irq, 1'b0);
        tdone("sof_irq");
        // Each endpoint: disabled neighbour first, then itself
        apb(1'b1, 12'h2f8, 32'h2);
        for (k = 0; k < 6; k++) begin
            apb(1'b1, 12'h2f0, 32'h1 << k);
            apb(1'b1, 12'h2fc, 32'h3);
            i_ep_src <= 30'h1 << (5 * ((k + 1) % 6) + 4);
            repeat (3) @(posedge i_clk);
            chk(o_ep_flag, 32'h1 << ((k + 1) % 6));
            chk(o_irq, 1'b0);
            i_ep_src <= 30'h1 << (5 * k + k % 5);
            repeat (3) @(posedge i_clk);
            chk(o_ep_flag, 32'h1 << k);
            chk(o_irq, 1'b1);
            i_ep_src <= 30'h0;
            repeat (3) @(posedge i_clk);
            chk(o_ep_flag, 32'h0);
        end
        tdone("endpoints");
        apb(1'b0, 12'h200, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, 12'h000, 32'hff);
        chk(err, 1'b1);
        tdone("unmapped");
        final_report();
    end
endmodule // usf_top_tb

bind usf_top usf_top_properties u_props (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_sof_pid(i_sof_pid), .i_ep_src(i_ep_src), .o_ep_flag(o_ep_flag),
    .o_sof_flag(o_sof_flag));
`default_nettype wire
